// file: mamd_cfg.svh
// Register indices, reset values, keys and address map bounds
`ifndef MAMD_CFG_SVH
`define MAMD_CFG_SVH
`define MAMD_NREG 73
`define MAMD_IX_PA_DATA 7'h00
`define MAMD_IX_PA_DIR 7'h01
`define MAMD_IX_PA_OPT 7'h02
`define MAMD_IX_ST_CTRL 7'h0B
`define MAMD_IX_ST_CAP 7'h0C
`define MAMD_IX_RT_CTRL 7'h0D
`define MAMD_IX_RT_CNTH 7'h0E
`define MAMD_IX_RT_CNTL 7'h0F
`define MAMD_IX_RT_RLDH 7'h10
`define MAMD_IX_RT_RLDL 7'h11
`define MAMD_IX_PWM_CTRL 7'h12
`define MAMD_IX_PWM0_CS 7'h13
`define MAMD_IX_PWM0_DH 7'h17
`define MAMD_IX_PWM0_DL 7'h18
`define MAMD_IX_FLASH_CS 7'h2F
`define MAMD_IX_CONV_CS 7'h34
`define MAMD_IX_CONV_H 7'h35
`define MAMD_IX_CONV_L 7'h36
`define MAMD_IX_EIRQ1 7'h37
`define MAMD_IX_MCLK_CS 7'h38
`define MAMD_IX_TRIM 7'h39
`define MAMD_IX_SYSINT 7'h3A
`define MAMD_IX_EIRQ2 7'h3D
`define MAMD_IX_AVD_TH 7'h3E
`define MAMD_IX_CKC_CS 7'h3F
`define MAMD_IX_KEY0 7'h47
`define MAMD_IX_KEY1 7'h48
`define MAMD_RST_PA_DIR 8'h08
`define MAMD_RST_PA_OPT 8'h02
`define MAMD_RST_TRIM 8'hFF
`define MAMD_RST_AVD_TH 8'h03
`define MAMD_RST_CKC_CS 8'h09
`define MAMD_KEY0_VAL 8'h55
`define MAMD_KEY1_VAL 8'hAA
`define MAMD_PIN_BIT 3
`define MAMD_REG_END 16'h007F
`define MAMD_RAM_END 16'h00FF
`define MAMD_STACK_BASE 16'h00C0
`define MAMD_FLASH_BASE 16'hFC00
`define MAMD_S0_BASE 16'hFE00
`define MAMD_S0_BASE_BIG 16'hFD00
`define MAMD_CAL_BASE 16'hDEE0
`define MAMD_CAL_END 16'hDEE3
`endif

// file: mamd_cpu_model.sv
// CPU-side register bus master model for the address map decoder
`timescale 1ns/1ns
`default_nettype none
module mamd_cpu_model (
   input wire logic clk_in,
   input wire logic pready_in,
   input wire logic [31:0] prdata_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [11:0] paddr_out,
   output logic [31:0] pwdata_out
);
   initial begin
      psel_out = 1'h0;
      penable_out = 1'h0;
      pwrite_out = 1'h0;
      paddr_out = 12'h000;
      pwdata_out = 32'h00000000;
   end
   // One transfer; reserved indices only where a test asks
   task automatic xfer(input logic w, input logic [6:0] i, input logic [7:0] d, output logic [7:0] r);
      @(posedge clk_in);
      psel_out <= 1'h1;
      penable_out <= 1'h0;
      pwrite_out <= w;
      paddr_out <= {3'h0, i, 2'h0};
      pwdata_out <= {24'h000000, d};
      @(posedge clk_in);
      penable_out <= 1'h1;
      do @(posedge clk_in); while (pready_in !== 1'h1);
      r = prdata_in[7:0];
      psel_out <= 1'h0;
      penable_out <= 1'h0;
      // Released lines show no stale value
      paddr_out <= ~paddr_out;
      pwdata_out <= ~pwdata_out;
   endtask
endmodule
`default_nettype wire

// file: mamd_pkg.sv
// Types shared by the address map decoder
`include "mamd_cfg.svh"
package mamd_pkg;
   typedef enum logic [2:0] {
      MAMD_RG_NONE = 3'h0,
      MAMD_RG_REG = 3'h1,
      MAMD_RG_RAM = 3'h2,
      MAMD_RG_FL0 = 3'h3,
      MAMD_RG_FL1 = 3'h4,
      MAMD_RG_CAL = 3'h5
   } mamd_region_t;
   typedef struct packed {
      logic [`MAMD_NREG-1:0][7:0] regs;
      logic [31:0] prdata;
      logic pready;
      logic pin_gpio;
      logic pin_val;
      mamd_region_t region;
      logic stack_hit;
      logic [7:0] cal;
      logic cal_vld;
   } mamd_state_t;
endpackage

// file: mamd_top.sv
// Register bank and address map decoder with APB slave
//
// Operation
// - After reset the shared bit-three pin acts as reset input.
// - Pin becomes general output after 55h in key0 and AAh in key1.
// - CPU address is 16 bits, spanning a 64K space.
// - Populated: 128 register bytes, 128 RAM bytes, 1K flash; rest empty except DEE0h-DEE3h.
// - Stack window is 00C0h to 00FFh, inside RAM, 64 bytes.
// - Vectors at the top lie in flash sector 0, FE00h-FFFFh.
// - Flash has two top sectors; sector 0 size set by option.
// - DEE0h-DEE3h return calibration bytes, readable in user mode only.
// - Calibration bytes survive a full flash erase.
// - Port A data, direction, option at 0,1,2 reset 00h,08h,02h.
// - Capture register at 000Ch is read-only, resets to zero.
// - Oscillator trim at 0039h is read/write, resets to FFh.
// - Clock controller status at 003Fh is read/write, resets to 09h.
// - Voltage threshold select at 003Eh is read/write, resets to 03h.
// - Converter high byte read-only; low byte resets to zero.
// - Port data reads give pin level for input bits.
// - Key registers at 0047h and 0048h, read/write, reset 00h.
`timescale 1ns/1ns
`default_nettype none
`include "mamd_cfg.svh"
module mamd_top #(
   parameter logic [31:0] CAL_VALUES = 32'h5A5A5A5A
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic [7:0] PORT_A_PINS_IN,
   input wire logic [7:0] CAPTURE_IN,
   input wire logic [15:0] COUNTER_IN,
   input wire logic [7:0] CONV_HIGH_IN,
   input wire logic [15:0] CPU_ADDR_IN,
   input wire logic USER_MODE_IN,
   input wire logic SECTOR0_OPT_IN,
   output logic [7:0] PORT_A_DATA_OUT,
   output logic [7:0] PORT_A_DIR_OUT,
   output logic PIN_GPIO_OUT,
   output logic SHARED_PIN_OUT,
   output logic [2:0] REGION_OUT,
   output logic STACK_HIT_OUT,
   output logic [7:0] CAL_DATA_OUT,
   output logic CAL_VALID_OUT
);
   // Calibration bytes live apart from flash (arbitrary default)
   //----------------------------------------
   // Register attributes
   //----------------------------------------
   function automatic logic is_impl(input logic [6:0] ix);
      case (ix)
         `MAMD_IX_PA_DATA, `MAMD_IX_PA_DIR, `MAMD_IX_PA_OPT, `MAMD_IX_ST_CTRL,
         `MAMD_IX_ST_CAP, `MAMD_IX_RT_CTRL, `MAMD_IX_RT_CNTH, `MAMD_IX_RT_CNTL,
         `MAMD_IX_RT_RLDH, `MAMD_IX_RT_RLDL, `MAMD_IX_PWM_CTRL, `MAMD_IX_PWM0_CS,
         `MAMD_IX_PWM0_DH, `MAMD_IX_PWM0_DL, `MAMD_IX_FLASH_CS, `MAMD_IX_CONV_CS,
         `MAMD_IX_CONV_H, `MAMD_IX_CONV_L, `MAMD_IX_EIRQ1, `MAMD_IX_MCLK_CS,
         `MAMD_IX_TRIM, `MAMD_IX_SYSINT, `MAMD_IX_EIRQ2, `MAMD_IX_AVD_TH,
         `MAMD_IX_CKC_CS, `MAMD_IX_KEY0, `MAMD_IX_KEY1: is_impl = 1'b1;
         default: is_impl = 1'b0;
      endcase
   endfunction

   function automatic logic is_ro(input logic [6:0] ix);
      is_ro = (ix == `MAMD_IX_ST_CAP) || (ix == `MAMD_IX_RT_CNTH) ||
              (ix == `MAMD_IX_RT_CNTL) || (ix == `MAMD_IX_CONV_H);
   endfunction

   function automatic mamd_pkg::mamd_state_t rst_state();
      mamd_pkg::mamd_state_t s;
      s = '0;
      s.region = mamd_pkg::MAMD_RG_NONE;
      s.regs[`MAMD_IX_PA_DIR] = `MAMD_RST_PA_DIR;
      s.regs[`MAMD_IX_PA_OPT] = `MAMD_RST_PA_OPT;
      s.regs[`MAMD_IX_TRIM] = `MAMD_RST_TRIM;
      s.regs[`MAMD_IX_AVD_TH] = `MAMD_RST_AVD_TH;
      s.regs[`MAMD_IX_CKC_CS] = `MAMD_RST_CKC_CS;
      return s;
   endfunction

   localparam mamd_pkg::mamd_state_t S_RST = rst_state();

   mamd_pkg::mamd_state_t s_q;
   mamd_pkg::mamd_state_t s_d;
   logic [6:0] ix;
   logic hit;
   logic [7:0] rd_byte;
   logic [7:0] dir;

   //----------------------------------------
   // Next state
   //----------------------------------------
   always_comb begin
      s_d = s_q;
      ix = PADDR_IN[8:2];
      dir = s_q.regs[`MAMD_IX_PA_DIR];
      hit = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN[11:9] == 3'h0) && is_impl(ix);
      // Unmapped index reads zero, write dropped
      rd_byte = 8'h00;
      if (hit) begin
         rd_byte = s_q.regs[ix];
      end
      if (hit && ix == `MAMD_IX_PA_DATA) begin
         rd_byte = (dir & s_q.regs[ix]) | (~dir & PORT_A_PINS_IN);
      end
      // Zero-wait slave: answer in first access cycle
      s_d.pready = 1'b0;
      if (PSEL_IN && !PENABLE_IN) begin
         s_d.pready = 1'b1;
         s_d.prdata = {24'h000000, rd_byte};
      end
      if (PSEL_IN && PENABLE_IN && s_q.pready && PWRITE_IN && hit && !is_ro(ix)) begin
         s_d.regs[ix] = PWDATA_IN[7:0];
      end
      // Read-only bytes follow their sources, writes ignored
      s_d.regs[`MAMD_IX_ST_CAP] = CAPTURE_IN;
      s_d.regs[`MAMD_IX_RT_CNTH] = COUNTER_IN[15:8];
      s_d.regs[`MAMD_IX_RT_CNTL] = COUNTER_IN[7:0];
      s_d.regs[`MAMD_IX_CONV_H] = CONV_HIGH_IN;
      // Unlock is sticky until the next reset
      if (s_q.regs[`MAMD_IX_KEY0] == `MAMD_KEY0_VAL && s_q.regs[`MAMD_IX_KEY1] == `MAMD_KEY1_VAL) begin
         s_d.pin_gpio = 1'b1;
      end
      s_d.pin_val = s_d.pin_gpio & s_d.regs[`MAMD_IX_PA_DATA][`MAMD_PIN_BIT];
      // CPU side decode
      s_d.region = mamd_pkg::MAMD_RG_NONE;
      s_d.stack_hit = 1'b0;
      s_d.cal_vld = 1'b0;
      s_d.cal = 8'h00;
      if (CPU_ADDR_IN <= `MAMD_REG_END) begin
         s_d.region = mamd_pkg::MAMD_RG_REG;
      end else if (CPU_ADDR_IN <= `MAMD_RAM_END) begin
         s_d.region = mamd_pkg::MAMD_RG_RAM;
         s_d.stack_hit = CPU_ADDR_IN >= `MAMD_STACK_BASE;
      end else if (CPU_ADDR_IN >= (SECTOR0_OPT_IN ? `MAMD_S0_BASE_BIG : `MAMD_S0_BASE)) begin
         s_d.region = mamd_pkg::MAMD_RG_FL0;
      end else if (CPU_ADDR_IN >= `MAMD_FLASH_BASE) begin
         s_d.region = mamd_pkg::MAMD_RG_FL1;
      end else if (CPU_ADDR_IN >= `MAMD_CAL_BASE && CPU_ADDR_IN <= `MAMD_CAL_END && USER_MODE_IN) begin
         s_d.region = mamd_pkg::MAMD_RG_CAL;
         s_d.cal_vld = 1'b1;
         s_d.cal = CAL_VALUES[{CPU_ADDR_IN[1:0], 3'h0} +: 8];
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         s_q <= S_RST;
      end else begin
         s_q <= s_d;
      end
   end

   //----------------------------------------
   // Outputs
   //----------------------------------------
   assign PRDATA_OUT = s_q.prdata;
   assign PREADY_OUT = s_q.pready;
   assign PSLVERR_OUT = 1'b0;
   assign PORT_A_DATA_OUT = s_q.regs[`MAMD_IX_PA_DATA];
   assign PORT_A_DIR_OUT = s_q.regs[`MAMD_IX_PA_DIR];
   assign PIN_GPIO_OUT = s_q.pin_gpio;
   assign SHARED_PIN_OUT = s_q.pin_val;
   assign REGION_OUT = s_q.region;
   assign STACK_HIT_OUT = s_q.stack_hit;
   assign CAL_DATA_OUT = s_q.cal;
   assign CAL_VALID_OUT = s_q.cal_vld;

   //----------------------------------------
   // Assertions
   //----------------------------------------
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   a_ready_after_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("pready held too long");
   a_unmapped_zero: assert property (PSEL_IN && !PENABLE_IN && PADDR_IN[8:2] == 7'h05 |=> PRDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   a_port_read_mix: assert property (PSEL_IN && !PENABLE_IN && PADDR_IN == 12'h000 |=>
      PRDATA_OUT[7:0] == (($past(PORT_A_DIR_OUT) & $past(PORT_A_DATA_OUT)) |
                          (~$past(PORT_A_DIR_OUT) & $past(PORT_A_PINS_IN))))
      else $error("port data read wrong");
   a_capture_ro: assert property (1'b1 |=> s_q.regs[`MAMD_IX_ST_CAP] == $past(CAPTURE_IN))
      else $error("capture register altered");
   a_unlock_keys: assert property ($rose(PIN_GPIO_OUT) |-> $past(s_q.regs[`MAMD_IX_KEY0]) == `MAMD_KEY0_VAL &&
      $past(s_q.regs[`MAMD_IX_KEY1]) == `MAMD_KEY1_VAL)
      else $error("pin unlocked without keys");
   a_pin_locked: assert property (!PIN_GPIO_OUT |-> !SHARED_PIN_OUT)
      else $error("pin driven while reset input");
   a_stack_in_ram: assert property (STACK_HIT_OUT |-> REGION_OUT == mamd_pkg::MAMD_RG_RAM)
      else $error("stack outside RAM");
   a_vector_sector0: assert property (CPU_ADDR_IN >= `MAMD_S0_BASE |=> REGION_OUT == mamd_pkg::MAMD_RG_FL0)
      else $error("vector not in sector 0");
   a_cal_user_only: assert property (CAL_VALID_OUT |-> $past(USER_MODE_IN))
      else $error("calibration read outside user mode");
   a_reg_window: assert property (CPU_ADDR_IN <= `MAMD_REG_END |=> REGION_OUT == mamd_pkg::MAMD_RG_REG)
      else $error("register window decode wrong");

   c_apb_write: cover property (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN);
   c_unlock: cover property ($rose(PIN_GPIO_OUT));
   c_cal_read: cover property (CAL_VALID_OUT);
   c_stack: cover property (STACK_HIT_OUT);
endmodule
`default_nettype wire

// file: mamd_top_test.sv
// Self-checking bench for the address map decoder
`timescale 1ns/1ns
`default_nettype none
module mamd_top_test;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel, penable, pwrite, pready, pslverr, gpio, shpin, stk, calv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] pins = 8'h00, cap = 8'h00, conv = 8'h00, pdata, pdir, cal, rd;
   logic [15:0] cnt = 16'h0000, caddr = 16'h0000;
   logic user = 1'h1, opt = 1'h0;
   logic [2:0] region;
   int n_fail = 0, num_checks = 0;
   always #20 clk = ~clk;
   // Calibration bytes are arbitrary
   mamd_top #(.CAL_VALUES(32'h44332211)) i_mamd_top (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PORT_A_PINS_IN(pins),
      .CAPTURE_IN(cap), .COUNTER_IN(cnt), .CONV_HIGH_IN(conv), .CPU_ADDR_IN(caddr), .USER_MODE_IN(user),
      .SECTOR0_OPT_IN(opt), .PORT_A_DATA_OUT(pdata), .PORT_A_DIR_OUT(pdir), .PIN_GPIO_OUT(gpio),
      .SHARED_PIN_OUT(shpin), .REGION_OUT(region), .STACK_HIT_OUT(stk), .CAL_DATA_OUT(cal),
      .CAL_VALID_OUT(calv));
   mamd_cpu_model i_mamd_cpu_model (.clk_in(clk), .pready_in(pready), .prdata_in(prdata),
      .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] i, input logic [7:0] d);
      i_mamd_cpu_model.xfer(1'h1, i, d, rd);
   endtask
   task automatic rdc(input logic [6:0] i, input logic [7:0] e);
      i_mamd_cpu_model.xfer(1'h0, i, 8'h00, rd);
      chk(rd, e);
   endtask
   task automatic dec(input logic [15:0] a, input logic o, input logic [2:0] er, input logic es);
      @(posedge clk);
      caddr <= a;
      opt <= o;
      @(posedge clk);
      @(negedge clk);
      chk(region, er);
      chk(stk, es);
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk(gpio, 1'h0);
      rdc(7'h00, 8'h00);
      rdc(7'h01, 8'h08);
      rdc(7'h02, 8'h02);
      rdc(7'h0C, 8'h00);
      rdc(7'h36, 8'h00);
      rdc(7'h39, 8'hFF);
      rdc(7'h3E, 8'h03);
      rdc(7'h3F, 8'h09);
      rdc(7'h47, 8'h00);
      rdc(7'h48, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_rw;
      wr(7'h39, 8'h5A);
      wr(7'h3E, 8'h3C);
      wr(7'h3F, 8'h06);
      wr(7'h36, 8'h81);
      cap <= 8'hC3;
      conv <= 8'h7E;
      wr(7'h0C, 8'h00);
      wr(7'h35, 8'h00);
      rdc(7'h39, 8'h5A);
      rdc(7'h3E, 8'h3C);
      rdc(7'h3F, 8'h06);
      rdc(7'h36, 8'h81);
      rdc(7'h0C, 8'hC3);
      rdc(7'h35, 8'h7E);
      wr(7'h03, 8'hFF);
      wr(7'h60, 8'hFF);
      rdc(7'h03, 8'h00);
      rdc(7'h60, 8'h00);
      rdc(7'h02, 8'h02);
      chk(pslverr, 1'h0);
      $display("test access done");
   endtask
   task automatic t_pins;
      wr(7'h01, 8'h0F);
      pins <= 8'h3C;
      wr(7'h00, 8'hA5);
      rdc(7'h00, 8'h35);
      chk(pdata, 8'hA5);
      chk(pdir, 8'h0F);
      wr(7'h47, 8'h55);
      wr(7'h00, 8'h08);
      repeat (2) @(posedge clk);
      chk(gpio, 1'h0);
      chk(shpin, 1'h0);
      wr(7'h48, 8'hAA);
      repeat (2) @(posedge clk);
      chk(gpio, 1'h1);
      chk(shpin, 1'h1);
      rdc(7'h47, 8'h55);
      rst_n <= 1'h0;
      repeat (8) @(posedge clk);
      chk(gpio, 1'h0);
      rst_n <= 1'h1;
      $display("test pin done");
   endtask
   task automatic t_map;
      dec(16'h0010, 1'h0, 3'h1, 1'h0);
      dec(16'h00BF, 1'h0, 3'h2, 1'h0);
      dec(16'h00C0, 1'h0, 3'h2, 1'h1);
      dec(16'h00FF, 1'h0, 3'h2, 1'h1);
      dec(16'h0100, 1'h0, 3'h0, 1'h0);
      dec(16'hFBFF, 1'h0, 3'h0, 1'h0);
      dec(16'hFC00, 1'h0, 3'h4, 1'h0);
      dec(16'hFD00, 1'h0, 3'h4, 1'h0);
      dec(16'hFD00, 1'h1, 3'h3, 1'h0);
      dec(16'hFE00, 1'h0, 3'h3, 1'h0);
      dec(16'hFFFF, 1'h0, 3'h3, 1'h0);
      dec(16'hDEE1, 1'h0, 3'h5, 1'h0);
      chk({calv, cal}, 9'h122);
      dec(16'hDEE3, 1'h0, 3'h5, 1'h0);
      chk({calv, cal}, 9'h144);
      @(posedge clk);
      user <= 1'h0;
      dec(16'hDEE3, 1'h0, 3'h0, 1'h0);
      chk(calv, 1'h0);
      $display("test map done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      t_reset;
      t_rw;
      t_pins;
      t_map;
      conclude;
   end
   initial begin
      repeat (4000) @(posedge clk);
      n_fail++;
      conclude;
   end
endmodule
`default_nettype wire
